/* File: smsr_pkg.sv */
// Shared constants and types for the synchronous master serial receiver
package smsr_pkg;

  // Register byte offsets on the Wishbone bus
  localparam logic [5:0] SMSR_OFS_RCV_STAT  = 6'h00;
  localparam logic [5:0] SMSR_OFS_RCV_BUF   = 6'h04;
  localparam logic [5:0] SMSR_OFS_XMT_BUF   = 6'h08;
  localparam logic [5:0] SMSR_OFS_XMT_STAT  = 6'h0C;
  localparam logic [5:0] SMSR_OFS_RATE_LINE = 6'h10;
  localparam logic [5:0] SMSR_OFS_DIV_HIGH  = 6'h14;
  localparam logic [5:0] SMSR_OFS_DIV_LOW   = 6'h18;
  localparam logic [5:0] SMSR_OFS_IRQ_STAT  = 6'h1C;
  localparam logic [5:0] SMSR_OFS_IRQ_MASK  = 6'h20;

  // Receive status/control fields
  localparam int SMSR_RC_PORT_EN  = 7;
  localparam int SMSR_RC_NINE_SEL = 6;
  localparam int SMSR_RC_SINGLE   = 5;
  localparam int SMSR_RC_CONT     = 4;
  localparam int SMSR_RC_OVERRUN  = 1;
  localparam int SMSR_RC_NINTH    = 0;
  localparam logic [7:0] SMSR_RC_WMASK = 8'hF8;

  // Transmit status/control fields
  localparam int SMSR_TC_CLK_SRC  = 7;
  localparam int SMSR_TC_XMT_EN   = 5;
  localparam int SMSR_TC_SYNC     = 4;
  localparam int SMSR_TC_SHIFT_MT = 1;
  localparam logic [7:0] SMSR_TC_WMASK = 8'hFD;

  // Rate and line control fields
  localparam int SMSR_RL_RCV_IDLE = 6;
  localparam int SMSR_RL_POLARITY = 4;
  localparam int SMSR_RL_DIV16    = 3;
  localparam logic [7:0] SMSR_RL_WMASK = 8'h3B;

  // Interrupt status and mask fields
  localparam int SMSR_IRQ_DONE    = 0;
  localparam int SMSR_IRQ_OVERRUN = 1;
  localparam int SMSR_IRQ_W       = 2;

  // Values after reset
  localparam logic [7:0] SMSR_RST_BYTE = 8'h00;
  localparam logic [1:0] SMSR_RST_IRQ  = 2'h0;
  localparam logic [15:0] SMSR_RST_DIV = 16'h0000;
  localparam logic [3:0] SMSR_RST_CNT  = 4'h0;
  localparam logic [8:0] SMSR_RST_SHIFT = 9'h000;

  // Bits in a word, less one
  localparam logic [3:0] SMSR_LAST8 = 4'h7;
  localparam logic [3:0] SMSR_LAST9 = 4'h8;

  typedef enum logic [1:0] {
    SMSR_IDLE,
    SMSR_REST,
    SMSR_ACTIVE
  } smsr_state_t;

  // Software-visible register contents
  typedef struct packed {
    logic [7:0] rcv_stat;
    logic [7:0] rcv_buf;
    logic [7:0] xmt_buf;
    logic [7:0] xmt_stat;
    logic [7:0] rate_line;
    logic [7:0] div_high;
    logic [7:0] div_low;
    logic [SMSR_IRQ_W-1:0] irq_stat;
    logic [SMSR_IRQ_W-1:0] irq_mask;
  } smsr_regs_t;

endpackage

/* File: smsr_sync.sv */
// Two-flop synchroniser for inputs from outside the clock domain
`timescale 1ns/1ns
module smsr_sync
  import smsr_pkg::*;
#(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         ce_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } smsr_sync_state_t;

  smsr_sync_state_t q;
  smsr_sync_state_t next_q;

  always_comb begin
    next_q.meta   = d_i;
    next_q.stable = q.meta;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
    end else if (ce_i) begin
      q <= next_q;
    end
  end

  assign q_o = q.stable;

endmodule

/* File: smsr_rate_gen.sv */
// Half-bit tick generator from the programmable rate divisor
`timescale 1ns/1ns
module smsr_rate_gen
  import smsr_pkg::*;
#(
  parameter int DIV_W = 16
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             ce_i,
  input  wire logic             run_i,
  input  wire logic [DIV_W-1:0] divisor_i,
  output logic                  tick_o
);

  typedef struct packed {
    logic [DIV_W-1:0] count;
  } smsr_rate_state_t;

  smsr_rate_state_t q;
  smsr_rate_state_t next_q;

  // One tick every divisor+1 cycles while running
  always_comb begin
    next_q = q;
    tick_o = 1'b0;
    if (!run_i) begin
      next_q.count = divisor_i;
    end else if (q.count == '0) begin
      tick_o       = 1'b1;
      next_q.count = divisor_i;
    end else begin
      next_q.count = q.count - 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q.count <= '0;
    end else if (ce_i) begin
      q <= next_q;
    end
  end

endmodule

/* File: smsr_top.sv */
// Synchronous master serial receiver with Wishbone register slave
`timescale 1ns/1ns
module smsr_top
  import smsr_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [5:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  output logic             irq_o,
  input  wire logic        serial_data_input_i,
  output logic             bidirectional_data_line_o,
  output logic             bidirectional_data_line_oe_o,
  output logic             shift_clock_line_o,
  output logic             shift_clock_line_oe_o
);

  typedef struct packed {
    smsr_regs_t  regs;
    logic        buf_full;
    smsr_state_t state;
    logic [3:0]  bit_cnt;
    logic [8:0]  shift;
    logic        clk_active;
    logic        ack;
    logic [7:0]  rdata;
  } smsr_top_state_t;

  smsr_top_state_t q;
  smsr_top_state_t next_q;

  logic        data_in;
  logic        tick;
  logic        rate_run;
  logic [15:0] divisor;

  // Byte-wide merge of a write under a writable-bit mask
  function automatic logic [7:0] merge_byte(input logic [7:0] old_v,
                                            input logic [7:0] new_v,
                                            input logic [7:0] wmask);
    merge_byte = (old_v & ~wmask) | (new_v & wmask);
  endfunction

  smsr_sync #(
    .W (1)
  ) u_data_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .ce_i  (ce_i),
    .d_i   (serial_data_input_i),
    .q_o   (data_in)
  );

  assign rate_run = (q.state != SMSR_IDLE);
  assign divisor  = q.regs.rate_line[SMSR_RL_DIV16] ?
                    {q.regs.div_high, q.regs.div_low} :
                    {8'h00, q.regs.div_low};

  smsr_rate_gen #(
    .DIV_W (16)
  ) u_rate_gen (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .ce_i      (ce_i),
    .run_i     (rate_run),
    .divisor_i (divisor),
    .tick_o    (tick)
  );

  logic                  req;
  logic                  wr;
  logic                  rd;
  logic [7:0]            wbyte;
  logic                  port_on;
  logic                  rx_enable;
  logic                  single_en;
  logic                  cont_en;
  logic                  xmt_en;
  logic [8:0]            new_shift;
  logic [3:0]            last_bit;
  logic                  word_done;
  logic [7:0]            word_low;
  logic                  word_ninth;
  logic [SMSR_IRQ_W-1:0] events;
  logic [7:0]            rd_byte;

  always_comb begin
    next_q     = q;
    req        = cyc_i & stb_i & ~q.ack;
    wr         = req & we_i & sel_i[0];
    rd         = req & ~we_i;
    wbyte      = dat_i[7:0];
    events     = '0;
    word_done  = 1'b0;
    rd_byte    = 8'h00;

    next_q.ack = req;

    // Register writes
    if (wr) begin
      unique case (adr_i)
        SMSR_OFS_RCV_STAT: begin
          next_q.regs.rcv_stat = merge_byte(q.regs.rcv_stat, wbyte, SMSR_RC_WMASK);
        end
        SMSR_OFS_XMT_BUF: begin
          next_q.regs.xmt_buf = wbyte;
        end
        SMSR_OFS_XMT_STAT: begin
          next_q.regs.xmt_stat = merge_byte(q.regs.xmt_stat, wbyte, SMSR_TC_WMASK);
        end
        SMSR_OFS_RATE_LINE: begin
          next_q.regs.rate_line = merge_byte(q.regs.rate_line, wbyte, SMSR_RL_WMASK);
        end
        SMSR_OFS_DIV_HIGH: begin
          next_q.regs.div_high = wbyte;
        end
        SMSR_OFS_DIV_LOW: begin
          next_q.regs.div_low = wbyte;
        end
        SMSR_OFS_IRQ_MASK: begin
          next_q.regs.irq_mask = wbyte[SMSR_IRQ_W-1:0];
        end
        default: begin
        end
      endcase
    end

    // Clearing continuous enable clears a pending overrun
    if (!next_q.regs.rcv_stat[SMSR_RC_CONT]) begin
      next_q.regs.rcv_stat[SMSR_RC_OVERRUN] = 1'b0;
    end

    // Register reads with their side effects
    if (rd) begin
      unique case (adr_i)
        SMSR_OFS_RCV_STAT: begin
          rd_byte = q.regs.rcv_stat;
        end
        SMSR_OFS_RCV_BUF: begin
          rd_byte         = q.regs.rcv_buf;
          next_q.buf_full = 1'b0;
        end
        SMSR_OFS_XMT_BUF: begin
          rd_byte = q.regs.xmt_buf;
        end
        SMSR_OFS_XMT_STAT: begin
          rd_byte = q.regs.xmt_stat;
          rd_byte[SMSR_TC_SHIFT_MT] = 1'b1;
        end
        SMSR_OFS_RATE_LINE: begin
          rd_byte = q.regs.rate_line;
          rd_byte[SMSR_RL_RCV_IDLE] = (q.state == SMSR_IDLE);
        end
        SMSR_OFS_DIV_HIGH: begin
          rd_byte = q.regs.div_high;
        end
        SMSR_OFS_DIV_LOW: begin
          rd_byte = q.regs.div_low;
        end
        SMSR_OFS_IRQ_STAT: begin
          rd_byte = {6'h00, q.regs.irq_stat};
          next_q.regs.irq_stat = '0;
        end
        SMSR_OFS_IRQ_MASK: begin
          rd_byte = {6'h00, q.regs.irq_mask};
        end
        default: begin
          rd_byte = 8'h00;
        end
      endcase
      next_q.rdata = rd_byte;
    end

    // Receive engine
    port_on   = q.regs.rcv_stat[SMSR_RC_PORT_EN] & q.regs.xmt_stat[SMSR_TC_SYNC]
                & q.regs.xmt_stat[SMSR_TC_CLK_SRC];
    single_en = q.regs.rcv_stat[SMSR_RC_SINGLE];
    cont_en   = q.regs.rcv_stat[SMSR_RC_CONT];
    xmt_en    = q.regs.xmt_stat[SMSR_TC_XMT_EN];
    rx_enable = port_on & (single_en | cont_en) & ~xmt_en;
    new_shift = {data_in, q.shift[8:1]};
    last_bit  = q.regs.rcv_stat[SMSR_RC_NINE_SEL] ? SMSR_LAST9 : SMSR_LAST8;
    word_low  = q.regs.rcv_stat[SMSR_RC_NINE_SEL] ? new_shift[7:0] : new_shift[8:1];
    word_ninth = q.regs.rcv_stat[SMSR_RC_NINE_SEL] & new_shift[8];

    unique case (q.state)
      SMSR_IDLE: begin
        next_q.clk_active = 1'b0;
        if (rx_enable) begin
          next_q.state   = SMSR_REST;
          next_q.bit_cnt = SMSR_RST_CNT;
          next_q.shift   = SMSR_RST_SHIFT;
        end
      end
      SMSR_REST: begin
        if (!rx_enable) begin
          next_q.state = SMSR_IDLE;
        end else if (tick) begin
          next_q.state      = SMSR_ACTIVE;
          next_q.clk_active = 1'b1;
        end
      end
      SMSR_ACTIVE: begin
        if (!rx_enable) begin
          next_q.state      = SMSR_IDLE;
          next_q.clk_active = 1'b0;
        end else if (tick) begin
          next_q.clk_active = 1'b0;
          next_q.shift      = new_shift;
          next_q.bit_cnt    = q.bit_cnt + 4'h1;
          next_q.state      = SMSR_REST;
          if (q.bit_cnt == last_bit) begin
            word_done      = 1'b1;
            next_q.bit_cnt = SMSR_RST_CNT;
            if (!cont_en) begin
              next_q.state = SMSR_IDLE;
              next_q.regs.rcv_stat[SMSR_RC_SINGLE] = 1'b0;
            end
          end
        end
      end
      default: begin
        next_q.state = SMSR_IDLE;
      end
    endcase

    // Word completion: deliver or flag overrun
    if (word_done) begin
      if (next_q.buf_full) begin
        events[SMSR_IRQ_OVERRUN] = 1'b1;
        next_q.regs.rcv_stat[SMSR_RC_OVERRUN] = 1'b1;
      end else begin
        events[SMSR_IRQ_DONE] = 1'b1;
        next_q.buf_full     = 1'b1;
        next_q.regs.rcv_buf = word_low;
        next_q.regs.rcv_stat[SMSR_RC_NINTH] = word_ninth;
      end
    end

    // Events set sticky bits; a set wins over a read clear
    next_q.regs.irq_stat = next_q.regs.irq_stat | events;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q.regs.rcv_stat  <= SMSR_RST_BYTE;
      q.regs.rcv_buf   <= SMSR_RST_BYTE;
      q.regs.xmt_buf   <= SMSR_RST_BYTE;
      q.regs.xmt_stat  <= SMSR_RST_BYTE;
      q.regs.rate_line <= SMSR_RST_BYTE;
      q.regs.div_high  <= SMSR_RST_BYTE;
      q.regs.div_low   <= SMSR_RST_BYTE;
      q.regs.irq_stat  <= SMSR_RST_IRQ;
      q.regs.irq_mask  <= SMSR_RST_IRQ;
      q.buf_full       <= 1'b0;
      q.state          <= SMSR_IDLE;
      q.bit_cnt        <= SMSR_RST_CNT;
      q.shift          <= SMSR_RST_SHIFT;
      q.clk_active     <= 1'b0;
      q.ack            <= 1'b0;
      q.rdata          <= SMSR_RST_BYTE;
    end else if (ce_i) begin
      q <= next_q;
    end
  end

  assign ack_o = q.ack;
  assign dat_o = {24'h00_0000, q.rdata};
  assign irq_o = |(q.regs.irq_stat & q.regs.irq_mask);

  // Pin assignment follows the port enable
  assign shift_clock_line_oe_o = port_on;
  assign shift_clock_line_o    = q.clk_active ^ q.regs.rate_line[SMSR_RL_POLARITY];
  assign bidirectional_data_line_oe_o = q.regs.rcv_stat[SMSR_RC_PORT_EN]
                                        & xmt_en & (q.state == SMSR_IDLE);
  assign bidirectional_data_line_o    = 1'b1;

endmodule

/* File: smsr_monitor.sv */
// Concurrent checks on the serial receiver's ports
`timescale 1ns/1ns
module smsr_monitor (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        ce_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire logic        irq_o,
  input wire logic        bidirectional_data_line_oe_o,
  input wire logic        shift_clock_line_o,
  input wire logic        shift_clock_line_oe_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_req;
    cyc_i && stb_i && !ack_o && ce_i;
  endsequence
  sequence s_clk_move;
    $changed(shift_clock_line_o) && !ack_o;
  endsequence

  a_ack_latency: assert property (s_req |=> ack_o)
    else $error("ack missing after request");
  a_ack_pulse: assert property (ack_o && ce_i |=> !ack_o)
    else $error("ack held longer than one cycle");
  a_ack_cause: assert property ($rose(ack_o) |-> $past(cyc_i && stb_i))
    else $error("ack without request");
  a_read_hold: assert property ($changed(dat_o) |-> $rose(ack_o))
    else $error("read data changed outside an access");
  a_upper_zero: assert property (dat_o[31:8] == 24'h00_0000)
    else $error("unused read bits not zero");
  a_irq_clear: assert property ($fell(irq_o) |-> ack_o)
    else $error("interrupt dropped without a bus access");
  a_clk_owned: assert property (s_clk_move |-> shift_clock_line_oe_o)
    else $error("shift clock moved while not driven");
  a_half_duplex: assert property (s_clk_move |-> !bidirectional_data_line_oe_o)
    else $error("data line driven during reception");
endmodule

/* File: smsr_peer.sv */
// Behavioural serial slave that shifts words out on the clock's active edge
`timescale 1ns/1ns
module smsr_peer (
  input  wire logic       sclk_i,
  input  wire logic       oe_i,
  input  wire logic       pol_i,
  input  wire logic       start_i,
  input  wire logic [8:0] word_i,
  input  wire logic [3:0] nbits_i,
  output logic            sdo_o,
  output int              edges_o
);
  int         idx;
  bit         odd;
  logic [8:0] w;
  wire        act = sclk_i ^ pol_i;

  initial sdo_o = 1'b0;

  // Alternate words are inverted so consecutive words differ
  always @(posedge act or posedge start_i) begin
    if (start_i) begin
      idx = 0;
      odd = 1'b0;
      edges_o = 0;
    end else if (oe_i) begin
      if (idx == 0) w = odd ? ~word_i : word_i;
      sdo_o = w[idx];
      edges_o++;
      idx++;
      if (idx == nbits_i) begin
        idx = 0;
        odd = ~odd;
      end
    end
  end

  // Hold ends after the last bit; the line then shows a changed value
  always @(negedge act) if (idx == 0) sdo_o = ~sdo_o;
  always @(negedge oe_i) sdo_o = ~sdo_o;
endmodule

/* File: testbench.sv */
// Register-level testbench for the serial receiver
`timescale 1ns/1ns
module testbench
  import smsr_pkg::*;
;
  logic        clk, rst, cyc, stb, we, sdi, start, pol, ack, irq, dout, doe, sclk, soe;
  logic [5:0]  adr;
  logic [31:0] wdat, rdat;
  logic [8:0]  word;
  logic [3:0]  nbits;
  logic [7:0]  q;
  int          bad_count, n_compared, edges, n, e;
  logic [5:0]  offs [8] = '{SMSR_OFS_RCV_STAT, SMSR_OFS_RCV_BUF, SMSR_OFS_XMT_BUF,
    SMSR_OFS_DIV_HIGH, SMSR_OFS_DIV_LOW, SMSR_OFS_IRQ_STAT, SMSR_OFS_IRQ_MASK, 6'h24};

  smsr_top i_dut (.clk_i(clk), .rst_i(rst), .ce_i(1'b1), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(4'hF), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
    .irq_o(irq), .serial_data_input_i(sdi), .bidirectional_data_line_o(dout),
    .bidirectional_data_line_oe_o(doe), .shift_clock_line_o(sclk),
    .shift_clock_line_oe_o(soe));
  smsr_peer i_peer (.sclk_i(sclk), .oe_i(soe), .pol_i(pol), .start_i(start),
    .word_i(word), .nbits_i(nbits), .sdo_o(sdi), .edges_o(edges));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wb(input logic w, input logic [5:0] a, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h00_0000, d};
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && k < 50);
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    if (k >= 50) bad_count++;
  endtask

  task automatic rd(input logic [5:0] a, input logic [7:0] exp, input logic [7:0] m);
    wb(1'b0, a, 8'h00);
    chk($sformatf("reg_%h", a), q & m, exp);
  endtask

  task automatic wait_irq();
    int k;
    k = 0;
    while (irq !== 1'b1 && k < 3000) begin
      @(posedge clk);
      k++;
    end
    if (k >= 3000) bad_count++;
  endtask

  task automatic frame(input logic [8:0] w, input logic [3:0] nb, input logic p);
    @(posedge clk);
    word <= w;
    nbits <= nb;
    pol <= p;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
  endtask

  initial begin
    {rst, cyc, stb, we, start, pol} = 6'h20;
    {adr, wdat, word, nbits} = '0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    foreach (offs[i]) rd(offs[i], 8'h00, 8'hFF);
    rd(SMSR_OFS_XMT_STAT, 8'h02, 8'hFF);
    rd(SMSR_OFS_RATE_LINE, 8'h40, 8'hFF);
    wb(1'b1, SMSR_OFS_RCV_STAT, 8'hFF);
    rd(SMSR_OFS_RCV_STAT, 8'hF8, 8'hFF);
    wb(1'b1, SMSR_OFS_RCV_STAT, 8'h00);
    $display("test reset done");
    wb(1'b1, SMSR_OFS_DIV_LOW, 8'h07);
    wb(1'b1, SMSR_OFS_XMT_STAT, 8'h90);
    wb(1'b1, SMSR_OFS_RCV_STAT, 8'h80);
    wb(1'b1, SMSR_OFS_IRQ_MASK, 8'h01);
    chk("clk_oe", {7'h00, soe}, 8'h01);
    chk("clk_idle", {7'h00, sclk}, 8'h00);
    frame(9'h0A5, 4'h8, 1'b0);
    wb(1'b1, SMSR_OFS_RCV_STAT, 8'hA0);
    wait_irq();
    rd(SMSR_OFS_IRQ_STAT, 8'h01, 8'hFF);
    chk("irq", {7'h00, irq}, 8'h00);
    rd(SMSR_OFS_RCV_STAT, 8'h80, 8'hFF);
    rd(SMSR_OFS_RCV_BUF, 8'hA5, 8'hFF);
    repeat (100) @(posedge clk);
    chk("edges", edges[7:0], 8'h08);
    $display("test single done");
    wb(1'b1, SMSR_OFS_IRQ_MASK, 8'h00);
    wb(1'b1, SMSR_OFS_RATE_LINE, 8'h10);
    chk("clk_idle", {7'h00, sclk}, 8'h01);
    frame(9'h15A, 4'h9, 1'b1);
    wb(1'b1, SMSR_OFS_RCV_STAT, 8'hE0);
    n = 0;
    do begin
      wb(1'b0, SMSR_OFS_RCV_STAT, 8'h00);
      n++;
    end while (q[5] !== 1'b0 && n < 200);
    chk("ninth", q, 8'hC1);
    chk("irq", {7'h00, irq}, 8'h00);
    rd(SMSR_OFS_IRQ_STAT, 8'h01, 8'hFF);
    rd(SMSR_OFS_RCV_BUF, 8'h5A, 8'hFF);
    $display("test nine bit done");
    wb(1'b1, SMSR_OFS_RATE_LINE, 8'h00);
    wb(1'b1, SMSR_OFS_IRQ_MASK, 8'h03);
    frame(9'h03C, 4'h8, 1'b0);
    wb(1'b1, SMSR_OFS_RCV_STAT, 8'hB0);
    wait_irq();
    rd(SMSR_OFS_IRQ_STAT, 8'h01, 8'hFF);
    rd(SMSR_OFS_RCV_BUF, 8'h3C, 8'hFF);
    wait_irq();
    rd(SMSR_OFS_IRQ_STAT, 8'h01, 8'hFF);
    wait_irq();
    rd(SMSR_OFS_IRQ_STAT, 8'h02, 8'hFF);
    rd(SMSR_OFS_RCV_STAT, 8'h12, 8'h12);
    rd(SMSR_OFS_RCV_BUF, 8'hC3, 8'hFF);
    wb(1'b1, SMSR_OFS_RCV_STAT, 8'h80);
    rd(SMSR_OFS_RCV_STAT, 8'h80, 8'hFE);
    e = edges;
    repeat (100) @(posedge clk);
    chk("edges", edges[7:0], e[7:0]);
    $display("test continuous done");
    wb(1'b1, SMSR_OFS_DIV_HIGH, 8'h01);
    wb(1'b1, SMSR_OFS_RATE_LINE, 8'h08);
    frame(9'h000, 4'h8, 1'b0);
    wb(1'b1, SMSR_OFS_RCV_STAT, 8'hA0);
    repeat (300) @(posedge clk);
    chk("edges", edges[7:0], 8'h01);
    wb(1'b1, SMSR_OFS_RCV_STAT, 8'h80);
    wb(1'b1, SMSR_OFS_RATE_LINE, 8'h00);
    $display("test divisor done");
    wb(1'b1, SMSR_OFS_XMT_STAT, 8'hB0);
    frame(9'h000, 4'h8, 1'b0);
    wb(1'b1, SMSR_OFS_RCV_STAT, 8'hA0);
    repeat (100) @(posedge clk);
    chk("edges", edges[7:0], 8'h00);
    chk("data_oe", {7'h00, doe}, 8'h01);
    chk("data_out", {7'h00, dout}, 8'h01);
    wb(1'b1, SMSR_OFS_RCV_STAT, 8'h80);
    $display("test half duplex done");
    close_out();
  end

  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    close_out();
  end
endmodule

bind smsr_top smsr_monitor i_mon (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
  .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o), .irq_o(irq_o),
  .bidirectional_data_line_oe_o(bidirectional_data_line_oe_o),
  .shift_clock_line_o(shift_clock_line_o), .shift_clock_line_oe_o(shift_clock_line_oe_o));
